// ==== hw/tlms_defs.svh ====
// Constants for the trigger link, mode and status block.
// Assumes inclusion by bare name from package and design modules.
`ifndef TLMS_DEFS_SVH
`define TLMS_DEFS_SVH

// Link word timing
`define WORD_NS        16
`define WORD_CYC       4
`define WORD_W         16

// Word layout
`define WT_HI          13
`define WT_LO          12
`define PAY_W          12
`define ST_PARITY      15
`define ST_BUSY        11

// Clock source codes selecting master mode
`define SRC_ONBOARD    3'h0
`define SRC_ECL        3'h1

// Control word payload that carries sync
`define CTRL_SYNC      12'h001

// Register byte offsets
`define OFS_CTRL       8'h00
`define OFS_TRIGTYPE   8'h04
`define OFS_FANOUT     8'h08
`define OFS_STATUS     8'h0C
`define OFS_INT_STAT   8'h10
`define OFS_INT_MASK   8'h14
`define OFS_EVENT      8'h18

// Control fields and reset values
`define CTRL_RX_SEL2   0
`define CTRL_GEN_EN    1
`define CTRL_P2_EN     2
`define CTRL_RST       3'h4
`define FANOUT_RST     8'hFF
`define TRIGTYPE_RST   12'h000

// Interrupt bits
`define INT_TRIG       0
`define INT_BUSY       1
`define INT_ORPHAN     2
`define INT_W          3

// Pending strobe queue
`define PEND_DEPTH     4
`define PEND_AW        2

`endif

// ==== hw/tlms_pkg.sv ====
// Types shared by the trigger link, mode and status block.
// Assumes the constants header is on the include path.
`include "tlms_defs.svh"

package tlms_pkg;

	typedef enum logic [1:0] {WT_TIME, WT_CTRL, WT_STROBE, WT_CONTENT} wtype_e;

	typedef enum {GEN_FREE, GEN_OWE_CONTENT} gen_e;

	typedef logic [`WORD_W-1:0] word_t;

	// Word type from bits 13 and 12
	function automatic wtype_e word_type(input word_t w);
		return wtype_e'(w[`WT_HI:`WT_LO]);
	endfunction

endpackage

// ==== hw/word_codec.sv ====
// Decoder of received trigger words and encoder of upstream status words.
// Assumes a word is presented whole in one cycle; purely combinational.
`timescale 1ns/10ps
`default_nettype none
`include "tlms_defs.svh"

module word_codec
	import tlms_pkg::*;
(
	input  wire logic [15:0] rx_word,    // Received trigger word
	input  wire logic        busy,       // Crate busy level
	output var  wtype_e      wtype,      // Decoded word type
	output logic      [11:0] payload,    // Type specific payload
	output logic      [15:0] status_word // Upstream status word
);

	logic [14:0] st_body;

	// Type and payload split
	assign wtype   = word_type(rx_word);
	assign payload = rx_word[`PAY_W-1:0];

	// Zeros above busy, busy flag, rest zero
	assign st_body = {3'h0, busy, 11'h000};

	// Even parity over bits 14 to 0
	assign status_word = {^st_body, st_body};

endmodule

`default_nettype wire

// ==== hw/trigger_link_mode_and_status.sv ====
// Trigger link decode, master mode word generation and crate status return.
// Assumes link words arrive already deserialized, synchronous to REF_CLK.
`timescale 1ns/10ps
`default_nettype none
`include "tlms_defs.svh"

module trigger_link_mode_and_status
	import tlms_pkg::*;
(
	input  wire logic        REF_CLK,         // System clock
	input  wire logic        NRST,            // Async reset, active low
	input  wire logic        CE,              // Clock enable
	input  wire logic [7:0]  ADDR,            // Register byte address
	input  wire logic [31:0] WDATA,           // Register write data
	input  wire logic        WR,              // Write strobe
	input  wire logic        RD,              // Read strobe
	output logic      [31:0] RDATA,           // Read data, cycle after RD
	output logic             IRQ,             // Interrupt level
	input  wire logic [2:0]  CLK_SRC,         // Clock source setting
	input  wire logic [15:0] RX1_WORD,        // Word from system supervisor
	input  wire logic        RX1_VALID,       // RX1 word strobe
	input  wire logic [15:0] RX2_WORD,        // Word from subsystem supervisor
	input  wire logic        RX2_VALID,       // RX2 word strobe
	input  wire logic        FP_TRIG,         // Front panel trigger
	input  wire logic        FP_SYNC,         // Front panel sync
	input  wire logic        DIST_BUSY,       // ORed busy from distribution
	input  wire logic        P2_BUSY_IN,      // Summed busy from fanout
	input  wire logic [15:0] SW_DATA,         // Switch slot event data
	input  wire logic        SW_VALID,        // Switch data strobe
	output logic             CRATE_TRIG,      // Crate trigger to port B
	output logic             P2_TRIG,         // P2 row C trigger
	output logic             P2_SYNC,         // P2 row C sync
	output logic      [15:0] TX_STATUS,       // Upstream status word
	output logic             TX_VALID,        // Status word strobe
	output logic      [15:0] FIB_WORD,        // Word to fiber outputs
	output logic      [7:0]  FIB_EN,          // Fiber output enables
	output logic      [23:0] TRIG_DATA,       // Strobe and content pair
	output logic             TRIG_DATA_VALID, // Pair strobe
	output logic             MASTER           // Master mode flag
);

	logic [1:0]  slot_q;
	logic        tick;
	logic        cfg_done_q;
	logic        master_q;
	logic [2:0]  ctrl_q;
	logic [11:0] trig_type_q;
	logic [7:0]  fanout_q;
	logic [`INT_W-1:0] int_stat_q;
	logic [`INT_W-1:0] int_mask_q;
	logic [`INT_W-1:0] ev;
	logic        fp_trig_q;
	logic        fp_sync_q;
	logic        trig_pend_q;
	logic        sync_pend_q;
	logic [13:0] time_q;
	logic [11:0] evt_q;
	gen_e        gen_q;
	logic [15:0] gen_word_q;
	logic        gen_valid_q;
	logic        gen_on;
	logic [15:0] rx_word;
	logic        rx_valid;
	wtype_e      wtype;
	logic [11:0] payload;
	logic [15:0] status_word;
	logic        busy_q;
	logic [11:0] pend_mem [`PEND_DEPTH];
	logic [`PEND_AW-1:0] wr_ptr_q;
	logic [`PEND_AW-1:0] rd_ptr_q;
	logic [`PEND_AW:0]   pend_cnt_q;
	logic        push;
	logic        pop;
	logic [15:0] sw_last_q;
	logic [27:0] event_q;
	logic [11:0] last_time_q;
	logic        is_strobe;
	logic        is_content;

	// Word slot: one link word per four clocks
	assign tick = (slot_q == 2'(`WORD_CYC - 1));

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			slot_q <= 2'h0;
		end else if (CE) begin
			slot_q <= slot_q + 2'h1;
		end
	end

	// Mode taken once, first enabled cycle after reset
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			cfg_done_q <= 1'b0;
			master_q   <= 1'b0;
		end else if (CE && !cfg_done_q) begin
			cfg_done_q <= 1'b1;
			master_q   <= (CLK_SRC == `SRC_ONBOARD) ||
			              (CLK_SRC == `SRC_ECL);
		end
	end

	// Generator enable counts only in master mode
	assign gen_on = master_q && ctrl_q[`CTRL_GEN_EN];

	// Front panel edges held until a slot sends them
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			fp_trig_q   <= 1'b0;
			fp_sync_q   <= 1'b0;
			trig_pend_q <= 1'b0;
			sync_pend_q <= 1'b0;
		end else if (CE) begin
			fp_trig_q <= FP_TRIG;
			fp_sync_q <= FP_SYNC;
			if (gen_on && FP_TRIG && !fp_trig_q) begin
				trig_pend_q <= 1'b1;
			end else if (tick && gen_q == GEN_FREE) begin
				trig_pend_q <= 1'b0;
			end
			if (gen_on && FP_SYNC && !fp_sync_q) begin
				sync_pend_q <= 1'b1;
			end else if (tick && !trig_pend_q && gen_q == GEN_FREE) begin
				sync_pend_q <= 1'b0;
			end
		end
	end

	// Master word generator: strobe, then content, else sync or time
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			gen_q       <= GEN_FREE;
			gen_word_q  <= 16'h0000;
			gen_valid_q <= 1'b0;
			time_q      <= 14'h0000;
			evt_q       <= 12'h000;
		end else if (CE) begin
			time_q      <= time_q + 14'h0001;
			gen_valid_q <= tick && gen_on;
			if (tick && gen_on) begin
				case (gen_q)
					GEN_FREE: begin
						if (trig_pend_q) begin
							gen_word_q <= {4'h2, trig_type_q};
							gen_q      <= GEN_OWE_CONTENT;
						end else if (sync_pend_q) begin
							gen_word_q <= {4'h1, `CTRL_SYNC};
						end else begin
							gen_word_q <= {4'h0, time_q[13:2]};
						end
					end
					GEN_OWE_CONTENT: begin
						gen_word_q <= {4'h3, evt_q};
						evt_q      <= evt_q + 12'h001;
						gen_q      <= GEN_FREE;
					end
					default: begin
						gen_q <= GEN_FREE;
					end
				endcase
			end
		end
	end

	// Word source: own words in master, chosen receiver otherwise
	always_comb begin
		if (master_q) begin
			rx_word  = gen_word_q;
			rx_valid = gen_valid_q;
		end else if (ctrl_q[`CTRL_RX_SEL2]) begin
			rx_word  = RX2_WORD;
			rx_valid = RX2_VALID;
		end else begin
			rx_word  = RX1_WORD;
			rx_valid = RX1_VALID;
		end
	end

	// Shared decode and status encode
	word_codec u_codec (
		.rx_word     (rx_word),
		.busy        (busy_q),
		.wtype       (wtype),
		.payload     (payload),
		.status_word (status_word)
	);

	assign is_strobe  = rx_valid && (wtype == WT_STROBE);
	assign is_content = rx_valid && (wtype == WT_CONTENT);
	assign push = is_strobe && (pend_cnt_q != (`PEND_AW+1)'(`PEND_DEPTH));
	assign pop  = is_content && (pend_cnt_q != '0);

	// Trigger outputs on strobe words, sync on sync control word
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			CRATE_TRIG <= 1'b0;
			P2_TRIG    <= 1'b0;
			P2_SYNC    <= 1'b0;
		end else if (CE) begin
			CRATE_TRIG <= is_strobe;
			P2_TRIG    <= is_strobe && ctrl_q[`CTRL_P2_EN];
			P2_SYNC    <= rx_valid && (wtype == WT_CTRL) &&
			              (payload == `CTRL_SYNC) && ctrl_q[`CTRL_P2_EN];
		end
	end

	// Strobe payload queue for in order pairing
	always_ff @(posedge REF_CLK) begin
		if (CE && push) begin
			pend_mem[wr_ptr_q] <= payload;
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			wr_ptr_q   <= '0;
			rd_ptr_q   <= '0;
			pend_cnt_q <= '0;
		end else if (CE) begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + (`PEND_AW)'(1);
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + (`PEND_AW)'(1);
			end
			pend_cnt_q <= pend_cnt_q + (`PEND_AW+1)'(push) - (`PEND_AW+1)'(pop);
		end
	end

	// Pair output and merged event record
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			TRIG_DATA       <= 24'h000000;
			TRIG_DATA_VALID <= 1'b0;
			sw_last_q       <= 16'h0000;
			event_q         <= 28'h0000000;
			last_time_q     <= 12'h000;
		end else if (CE) begin
			TRIG_DATA_VALID <= pop;
			if (SW_VALID) begin
				sw_last_q <= SW_DATA;
			end
			if (pop) begin
				TRIG_DATA <= {pend_mem[rd_ptr_q], payload};
				event_q   <= {sw_last_q, payload};
			end
			if (rx_valid && wtype == WT_TIME) begin
				last_time_q <= payload;
			end
		end
	end

	// Crate busy from distribution board and P2 fanout
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			busy_q <= 1'b0;
		end else if (CE) begin
			busy_q <= DIST_BUSY || P2_BUSY_IN;
		end
	end

	// Upstream status word, one per slot
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			TX_STATUS <= 16'h0000;
			TX_VALID  <= 1'b0;
		end else if (CE) begin
			TX_VALID <= tick;
			if (tick) begin
				TX_STATUS <= status_word;
			end
		end
	end

	// Fiber fanout and mode flag
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			FIB_WORD <= 16'h0000;
			FIB_EN   <= 8'h00;
			MASTER   <= 1'b0;
		end else if (CE) begin
			MASTER   <= master_q;
			FIB_WORD <= master_q ? gen_word_q : 16'h0000;
			FIB_EN   <= master_q ? fanout_q : 8'h00;
		end
	end

	// Register writes
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			ctrl_q      <= `CTRL_RST;
			trig_type_q <= `TRIGTYPE_RST;
			fanout_q    <= `FANOUT_RST;
			int_mask_q  <= '0;
		end else if (CE && WR) begin
			case (ADDR)
				`OFS_CTRL:     ctrl_q      <= WDATA[2:0];
				`OFS_TRIGTYPE: trig_type_q <= WDATA[11:0];
				`OFS_FANOUT:   fanout_q    <= WDATA[7:0];
				`OFS_INT_MASK: int_mask_q  <= WDATA[`INT_W-1:0];
				default:       ctrl_q      <= ctrl_q;
			endcase
		end
	end

	// Events: trigger issued, busy rise, unpaired or overflowed word
	assign ev[`INT_TRIG]   = is_strobe;
	assign ev[`INT_BUSY]   = (DIST_BUSY || P2_BUSY_IN) && !busy_q;
	assign ev[`INT_ORPHAN] = (is_content && !pop) || (is_strobe && !push);

	// Sticky status, cleared by read, new event wins
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			int_stat_q <= '0;
			IRQ        <= 1'b0;
		end else if (CE) begin
			int_stat_q <= ((RD && ADDR == `OFS_INT_STAT) ? '0 : int_stat_q) | ev;
			IRQ        <= |(int_stat_q & int_mask_q);
		end
	end

	// Register reads, data in the following cycle
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			RDATA <= 32'h00000000;
		end else if (CE) begin
			if (RD) begin
				case (ADDR)
					`OFS_CTRL:     RDATA <= {29'h0, ctrl_q};
					`OFS_TRIGTYPE: RDATA <= {20'h0, trig_type_q};
					`OFS_FANOUT:   RDATA <= {24'h0, fanout_q};
					`OFS_STATUS:   RDATA <= {4'h0, last_time_q, 11'h0,
					                         pend_cnt_q, busy_q, master_q};
					`OFS_INT_STAT: RDATA <= {29'h0, int_stat_q};
					`OFS_INT_MASK: RDATA <= {29'h0, int_mask_q};
					`OFS_EVENT:    RDATA <= {4'h0, event_q};
					default:       RDATA <= 32'h00000000;
				endcase
			end else begin
				RDATA <= 32'h00000000;
			end
		end
	end

endmodule

`default_nettype wire

// ==== tb/tlms_monitor.sv ====
// Port assertions for the trigger link, mode and status block.
// Assumes binding to the top module, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module tlms_monitor (
	input wire logic        REF_CLK,         // Clock
	input wire logic        NRST,            // Reset
	input wire logic        CE,              // Enable
	input wire logic        RD,              // Read
	input wire logic [31:0] RDATA,           // Read data
	input wire logic [15:0] RX1_WORD,        // Link 1
	input wire logic        RX1_VALID,       // Link 1 strobe
	input wire logic [15:0] RX2_WORD,        // Link 2
	input wire logic        RX2_VALID,       // Link 2 strobe
	input wire logic        DIST_BUSY,       // Distribution busy
	input wire logic        P2_BUSY_IN,      // Fanout busy
	input wire logic        CRATE_TRIG,      // Trigger
	input wire logic        P2_TRIG,         // P2 trigger
	input wire logic [15:0] TX_STATUS,       // Status word
	input wire logic        TX_VALID,        // Status strobe
	input wire logic [15:0] FIB_WORD,        // Fiber word
	input wire logic [7:0]  FIB_EN,          // Fiber enables
	input wire logic        TRIG_DATA_VALID, // Pair strobe
	input wire logic        MASTER           // Mode
);
	logic rx_strobe;
	logic rx_content;

	// Word types on either link
	assign rx_strobe  = (RX1_VALID && RX1_WORD[13:12] == 2'h2) ||
		(RX2_VALID && RX2_WORD[13:12] == 2'h2);
	assign rx_content = (RX1_VALID && RX1_WORD[13:12] == 2'h3) ||
		(RX2_VALID && RX2_WORD[13:12] == 2'h3);

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!NRST);

	// Three idle cycles, then the next status word
	sequence s_gap;
		!TX_VALID [*3] ##1 TX_VALID;
	endsequence

	a_tx_period: assert property (disable iff (!NRST || !CE) TX_VALID |=> s_gap)
		else $error("status spacing wrong");
	a_status_zeros: assert property (TX_VALID |->
		TX_STATUS[14:12] == 3'h0 && TX_STATUS[10:0] == 11'h000) else $error("status zeros");
	a_status_parity: assert property (TX_VALID |-> !(^TX_STATUS))
		else $error("status parity");
	a_busy_forward: assert property (TX_VALID |->
		TX_STATUS[11] == $past(DIST_BUSY || P2_BUSY_IN, 2)) else $error("busy not sent");
	a_trig_cause: assert property (CRATE_TRIG |-> $past(rx_strobe) || MASTER)
		else $error("trigger without strobe");
	a_pair_cause: assert property (TRIG_DATA_VALID |-> $past(rx_content) || MASTER)
		else $error("pair without content");
	a_p2_follow: assert property (P2_TRIG |-> CRATE_TRIG)
		else $error("p2 trigger alone");
	a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h00000000)
		else $error("read data not idle");
	a_std_fibers: assert property ($past(NRST, 5) && !MASTER |->
		FIB_EN == 8'h00 && FIB_WORD == 16'h0000) else $error("fibers in standard");
	a_mode_hold: assert property ($past(NRST, 4) |-> $stable(MASTER))
		else $error("mode changed");
endmodule

bind trigger_link_mode_and_status tlms_monitor i_mon (
	.REF_CLK, .NRST, .CE, .RD, .RDATA, .RX1_WORD, .RX1_VALID, .RX2_WORD, .RX2_VALID,
	.DIST_BUSY, .P2_BUSY_IN, .CRATE_TRIG, .P2_TRIG, .TX_STATUS, .TX_VALID, .FIB_WORD,
	.FIB_EN, .TRIG_DATA_VALID, .MASTER
);
`default_nettype wire

// ==== tb/upstream_board.sv ====
// Model of the upstream board sending words down the trigger link.
// Assumes the bench queues words through the push task.
`timescale 1ns/10ps
`default_nettype none
module upstream_board (
	input  wire logic        clk,   // System clock
	input  wire logic        nrst,  // Reset, active low
	output logic      [15:0] word,  // Link word
	output logic             valid  // Word strobe
);
	logic [15:0] q[$];
	logic [1:0]  slot_q;

	// Queue a word for a later slot
	task automatic push(input logic [15:0] w);
		q.push_back(w);
	endtask

	// One word per four clocks; idle line shows the inverse
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			slot_q <= 2'h0;
			valid  <= 1'h0;
			word   <= 16'h0000;
		end else begin
			slot_q <= slot_q + 2'h1;
			if (slot_q == 2'h0 && q.size() > 0) begin
				word  <= q.pop_front();
				valid <= 1'h1;
			end else begin
				valid <= 1'h0;
				word  <= ~word;
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/tb_trigger_link_mode_and_status.sv ====
// Self-checking bench for the trigger link, mode and status block.
// Assumes package, link model and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "tlms_defs.svh"
module tb_trigger_link_mode_and_status
	import tlms_pkg::*;
;
	logic        REF_CLK, NRST, CE, WR, RD, IRQ, FP_TRIG, FP_SYNC, DIST_BUSY, P2_BUSY_IN;
	logic        SW_VALID, RX1_VALID, RX2_VALID, CRATE_TRIG, P2_TRIG, P2_SYNC, TX_VALID;
	logic        TRIG_DATA_VALID, MASTER, track, sel2, rnd, e_trig, e_tchk, e_sync, e_pair;
	logic        b1, b2, orph, s_trig, s_fib, s_sync, s_pair;
	logic [2:0]  CLK_SRC;
	logic [7:0]  ADDR, FIB_EN;
	logic [11:0] tt, last_t;
	logic [15:0] RX1_WORD, RX2_WORD, SW_DATA, TX_STATUS, FIB_WORD, w, sw_m, held;
	logic [23:0] TRIG_DATA, e_data;
	logic [27:0] e_evt;
	logic [31:0] WDATA, RDATA;
	logic [11:0] pend[$];
	int          miscompares, n_checks;

	upstream_board i_up1 (.clk(REF_CLK), .nrst(NRST), .word(RX1_WORD), .valid(RX1_VALID));
	upstream_board i_up2 (.clk(REF_CLK), .nrst(NRST), .word(RX2_WORD), .valid(RX2_VALID));
	trigger_link_mode_and_status i_dut (.REF_CLK, .NRST, .CE, .ADDR, .WDATA, .WR, .RD,
		.RDATA, .IRQ, .CLK_SRC, .RX1_WORD, .RX1_VALID, .RX2_WORD, .RX2_VALID, .FP_TRIG,
		.FP_SYNC, .DIST_BUSY, .P2_BUSY_IN, .SW_DATA, .SW_VALID, .CRATE_TRIG, .P2_TRIG,
		.P2_SYNC, .TX_STATUS, .TX_VALID, .FIB_WORD, .FIB_EN, .TRIG_DATA,
		.TRIG_DATA_VALID, .MASTER);

	// 40 MHz clock
	initial begin
		REF_CLK = 1'h0;
		forever #12.5 REF_CLK = ~REF_CLK;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge REF_CLK);
		ADDR  <= a;
		WDATA <= d;
		WR    <= 1'h1;
		@(posedge REF_CLK);
		WR <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge REF_CLK);
		ADDR <= a;
		RD   <= 1'h1;
		@(posedge REF_CLK);
		RD <= 1'h0;
		#1 check(RDATA, exp);
	endtask

	// Random words on both links, then let them drain
	task automatic traffic(input int n);
		for (int i = 0; i < n; i++) begin
			i_up1.push(16'($urandom));
			i_up2.push(16'($urandom));
		end
		repeat (4 * n + 8) @(posedge REF_CLK);
	endtask

	task automatic do_reset(input logic [2:0] src);
		@(posedge REF_CLK);
		track = 1'h0;
		NRST    <= 1'h0;
		CLK_SRC <= src;
		repeat (3) @(posedge REF_CLK);
		NRST <= 1'h1;
		pend.delete();
	endtask

	// Note what the looped-back generator produced
	task automatic watch(input int n);
		repeat (n) begin
			@(posedge REF_CLK);
			#1;
			if (CRATE_TRIG === 1'h1) s_trig = 1'h1;
			if (FIB_WORD === {4'h2, tt}) s_fib = 1'h1;
			if (P2_SYNC === 1'h1) s_sync = 1'h1;
			if (TRIG_DATA_VALID === 1'h1 && TRIG_DATA[23:12] === tt) s_pair = 1'h1;
		end
	endtask

	// Reference decode and pairing of the selected link
	always @(posedge REF_CLK) begin
		if (NRST && track) begin
			check(TRIG_DATA_VALID, e_pair);
			if (e_pair) check(TRIG_DATA, e_data);
			check(P2_SYNC, e_sync);
			check(CRATE_TRIG, e_trig);
			check(P2_TRIG, e_trig);
		end
		w = sel2 ? RX2_WORD : RX1_WORD;
		{e_trig, e_sync, e_pair, e_tchk} = 4'h1;
		if (sel2 ? RX2_VALID : RX1_VALID) begin
			case (w[13:12])
				2'h1: e_sync = (w[11:0] == 12'h001);
				2'h2: begin
					e_trig = 1'h1;
					e_tchk = (pend.size() < 4);
					if (e_tchk) pend.push_back(w[11:0]);
					else orph = 1'h1;
				end
				2'h3: begin
					e_pair = (pend.size() > 0);
					if (e_pair) begin
						e_data = {pend.pop_front(), w[11:0]};
						e_evt  = {sw_m, w[11:0]};
					end else begin
						orph = 1'h1;
					end
				end
				2'h0: last_t = w[11:0];
				default: ;
			endcase
		end
		// Last switch data, taken after pairing as the design does
		if (SW_VALID === 1'h1) sw_m = SW_DATA;
	end

	// Status word from busy two cycles back
	always @(posedge REF_CLK) begin
		if (NRST && TX_VALID === 1'h1) check(TX_STATUS, {b2, 3'h0, b2, 11'h000});
		b2 = b1;
		b1 = DIST_BUSY | P2_BUSY_IN;
	end

	// Random side inputs while enabled
	always @(posedge REF_CLK) begin
		if (rnd) begin
			{FP_TRIG, FP_SYNC, DIST_BUSY, P2_BUSY_IN, SW_VALID} <= 5'($urandom);
			SW_DATA <= 16'($urandom);
		end
	end

	// Main sequence
	initial begin
		{NRST, WR, RD, FP_TRIG, FP_SYNC, DIST_BUSY, P2_BUSY_IN, SW_VALID} = 8'h00;
		{track, sel2, rnd, b1, b2, orph, s_trig, s_fib, s_sync, s_pair} = 10'h000;
		{e_trig, e_tchk, e_sync, e_pair} = 4'h0;
		{ADDR, WDATA, SW_DATA, tt} = 68'h0;
		{last_t, sw_m, held, e_evt} = 72'h0;
		CE = 1'h1;
		CLK_SRC = 3'h2;
		miscompares = 0;
		n_checks = 0;
		void'($urandom(32'h00454B74));
		repeat (3) @(posedge REF_CLK);
		NRST <= 1'h1;
		track = 1'h1;
		rd(`OFS_CTRL, `CTRL_RST);
		rd(`OFS_TRIGTYPE, `TRIGTYPE_RST);
		rd(`OFS_FANOUT, `FANOUT_RST);
		rd(`OFS_INT_MASK, 32'h0);
		rd(8'h1C, 32'h0);
		check(MASTER, 1'h0);
		rnd <= 1'h1;
		traffic(60);
		wr(`OFS_CTRL, 32'h7);
		sel2 <= 1'h1;
		traffic(60);
		rnd <= 1'h0;
		@(posedge REF_CLK);
		{FP_TRIG, FP_SYNC, DIST_BUSY, P2_BUSY_IN, SW_VALID} <= 5'h00;
		repeat (6) @(posedge REF_CLK);
		#1 check(IRQ, 1'h0);
		wr(`OFS_INT_MASK, 32'h7);
		repeat (3) @(posedge REF_CLK);
		#1 check(IRQ, 1'h1);
		rd(`OFS_INT_STAT, {orph, 2'h3});
		repeat (3) @(posedge REF_CLK);
		#1 check(IRQ, 1'h0);
		rd(`OFS_INT_STAT, 32'h0);
		rd(`OFS_STATUS, {4'h0, last_t, 11'h000, 3'(pend.size()), 2'h0});
		rd(`OFS_EVENT, {4'h0, e_evt});
		for (int i = 7; i >= 0; i--) begin
			do_reset(3'(i));
			repeat (4) @(posedge REF_CLK);
			CLK_SRC <= 3'(i) ^ 3'h2;
			repeat (4) @(posedge REF_CLK);
			#1 check(MASTER, i < 2);
		end
		check(FIB_EN, `FANOUT_RST);
		wr(`OFS_FANOUT, 32'h5A);
		repeat (3) @(posedge REF_CLK);
		#1 check(FIB_EN, 8'h5A);
		tt = 12'($urandom);
		wr(`OFS_TRIGTYPE, {20'h0, tt});
		wr(`OFS_CTRL, 32'h6);
		@(posedge REF_CLK);
		FP_TRIG <= 1'h1;
		watch(40);
		FP_TRIG <= 1'h0;
		FP_SYNC <= 1'h1;
		watch(40);
		FP_SYNC <= 1'h0;
		check(s_trig, 1'h1);
		check(s_fib, 1'h1);
		check(s_pair, 1'h1);
		check(s_sync, 1'h1);
		// Clock enable low must freeze the generated word stream
		@(posedge REF_CLK);
		CE <= 1'h0;
		@(posedge REF_CLK);
		#1 held = FIB_WORD;
		repeat (8) @(posedge REF_CLK);
		#1 check(FIB_WORD, held);
		CE <= 1'h1;
		repeat (8) @(posedge REF_CLK);
		#1 check(FIB_WORD != held, 1'h1);
		end_of_test();
	end

	// Watchdog against a hang
	initial begin
		#400000;
		miscompares++;
		end_of_test();
	end
endmodule
`default_nettype wire
